//--- lecr_defines.vh
// Constants for the link error and capability register bank.
// Assumes a 32-bit classic Wishbone slave, byte addressed, one word each.
`ifndef LECR_DEFINES_VH
`define LECR_DEFINES_VH

// Register indexes; byte address is four times the index
`define LECR_IDX_LINK_ERR 6'h09
`define LECR_IDX_RATE_SUP 6'h0a
`define LECR_IDX_FEATURES 6'h0c
`define LECR_IDX_SCRATCH 6'h10
`define LECR_IDX_ERR_ROUTE 6'h12
`define LECR_ADR_LSB 2
`define LECR_ADR_MSB 7

// Link error byte fields
`define LECR_LE_PROT 4
`define LECR_LE_OVFL 5
`define LECR_LE_EOC 6
`define LECR_LE_TMO 7

// Rate support mask fields
`define LECR_RS_BASE 0
`define LECR_RS_VENDOR 15

// Feature flag fields
`define LECR_FT_ISOC 0
`define LECR_FT_STOP 1
`define LECR_FT_CRCT 2
`define LECR_FT_XCTL 3
`define LECR_FT_XREG 8

// Error routing fields
`define LECR_ER_PROT_FLOOD 0
`define LECR_ER_OVFL_FLOOD 1
`define LECR_ER_PROT_FATAL 2

// Reset values
`define LECR_RST_BYTE 8'h00
`define LECR_RST_HALF 16'h0000
`define LECR_RST_WORD 32'h00000000
`define LECR_RST_CNT 27'h0000000
`define LECR_CNT_ONE 27'h0000001

// Control lane timeouts in microseconds, clock rate in MHz
`define LECR_CTL_TMO_SHORT_US 1000
`define LECR_CTL_TMO_LONG_US 1000000
`define LECR_CLK_MHZ 125

`endif

//--- lecr_regs.v
// Link error log, capability and error routing registers on Wishbone.
// Assumes link-side inputs are asynchronous and are resynchronised here;
// transmitter hand-off signals come from logic on CLK_SYS.
`timescale 1ns/100ps
`include "lecr_defines.vh"

// Behaviour
// - Link error field sits in bits 7:4 of the link rate byte, one link.
// - Log bits of unchecked error conditions read constant zero.
// - Protocol violation sets bit 4; write one clears; cold reset zeroes.
// - Receive overflow sets bit 5; write one clears; cold reset zeroes.
// - Posted request or response sent at chain end sets bit 6.
// - Bit 7 picks control lane timeout 1 ms or 1 s; warm reset zeroes.
// - Timeout bit is absent when no protocol checking is built.
// - Sixteen-bit read-only rate support mask, bit N for encoding N.
// - Rate mask bit 0 always reads one for the base rate.
// - Rate mask bit 15 reads one only with vendor-specific rates.
// - Feature bit 0 reports isochronous flow control support.
// - Feature bit 1 reports link stop request protocol support.
// - Feature bit 2 reports CRC testing mode support.
// - Feature bit 3 reports need for extended control lane time.
// - Feature bit 8 shows scratchpad and routing registers present.
// - Extended register set flag exists only in host or secondary blocks.
// - Scratchpad stores software values, cold reset clears it.
// - Protocol flood enable with protocol log set floods Sync packets.
// - Overflow flood enable with overflow log set floods Sync packets.
// - Flood enables survive chain resets; only warm or cold reset clears.
// - Protocol fatal enable with protocol log set raises fatal interrupt.
// - Unchecked conditions tie their log and routing bits to zero.
module lecr_regs #(
    parameter HAS_PROT_CHECK = 1,
    parameter HAS_OVFL_CHECK = 1,
    parameter HAS_EOC_CHECK = 1,
    parameter HAS_FATAL_IRQ = 1,
    parameter HOST_OR_SECONDARY = 0,
    parameter [15:0] RATE_SUPPORT = 16'h0001,
    parameter VENDOR_RATES = 0,
    parameter FEAT_ISOC = 0,
    parameter FEAT_STOP = 1,
    parameter FEAT_CRC_TEST = 0,
    parameter FEAT_EXT_CTL = 0,
    parameter [26:0] CTL_TMO_SHORT_CYC =
        `LECR_CTL_TMO_SHORT_US * `LECR_CLK_MHZ,
    parameter [26:0] CTL_TMO_LONG_CYC =
        `LECR_CTL_TMO_LONG_US * `LECR_CLK_MHZ
) (
    input wire CLK_SYS,
    input wire RST_N,
    input wire WARM_RST_N,
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire WB_WE_I,
    input wire [7:0] WB_ADR_I,
    input wire [3:0] WB_SEL_I,
    input wire [31:0] WB_DAT_I,
    output wire [31:0] WB_DAT_O,
    output wire WB_ACK_O,
    input wire LINK_CLK,
    input wire CONTROL_LANE,
    input wire PROT_ERR,
    input wire OVFL_ERR,
    input wire END_OF_CHAIN,
    input wire TX_POSTED_OR_RESP,
    output wire SYNC_FLOOD,
    output wire FATAL_ERR
);

    // Byte-lane merge of a write into a 16-bit register
    function [15:0] lecr_merge;
        input [15:0] old;
        input [15:0] wdat;
        input [1:0] sel;
        begin
            lecr_merge = old;
            if (sel[0])
                lecr_merge[7:0] = wdat[7:0];
            if (sel[1])
                lecr_merge[15:8] = wdat[15:8];
        end
    endfunction

    // Overview of the bank
    // The bank holds one link copy only. The link error nibble shares
    // its byte with the rate select nibble, which lives elsewhere and
    // reads zero here. All registers are sixteen bits or less and sit
    // in the low half of the data word; the upper half reads zero.
    //
    // Clocking
    // Everything runs on CLK_SYS. The link clock is not used as a
    // clock: it is sampled, resynchronised and turned into a rising
    // edge strobe, so the link must run well below half of CLK_SYS.
    // The error lines from the link receiver are held for at least one
    // link period, so sampling them at the strobe cannot miss them.
    //
    // Resets
    // The cold reset is asynchronous and clears every flip-flop. The
    // warm reset is a synchronous level on CLK_SYS and touches only the
    // timeout select and the routing enables; the logs and scratchpad
    // keep their values so software can inspect them after recovery.
    // No chain reset input exists, so a bridge chain reset cannot drop
    // the flood enables; software must clear them itself.
    //
    // Log bits
    // Each log bit is set by hardware and cleared by writing a one. A
    // set and a clear in one cycle leave the bit set, so no event is
    // lost to a racing clear. A clear with no byte lane zero enabled
    // has no effect.
    //
    // Control lane timeout
    // The counter runs while the resynchronised lane is low and
    // restarts when it goes high. Reaching the limit gives one
    // protocol error event per low period. The limit follows the
    // timeout select bit; changing that bit mid-count takes effect at
    // once, and a counter already past a shorter limit stays parked.
    // The long limit must fit the counter width, which it does.
    //
    // Reporting
    // The flood and fatal outputs are registered from log and enable,
    // so they follow either one cycle late. The fatal output is only
    // live when the block is built with a fatal interrupt.
    //
    // Bus
    // The slave answers every request with a one-cycle ack on the next
    // edge, including unmapped indexes and writes to read-only words.
    // Writes take effect at the edge that takes the request. A held
    // request is blocked for the ack cycle, so a master that keeps its
    // strobe up is not answered twice for one access.
    //
    // Build options
    // Each check can be left out; its log and enable bits then read
    // zero and ignore writes. Capability bits are fixed by parameters.
    //
    // Hazards
    // A transmitter hand-off is taken as a one-cycle pulse; a longer
    // pulse at chain end still only sets the log once in effect.
    // Error lines that glitch shorter than a link period may be missed.
    // Read data stays in its register until the next request.

    reg [3:0] sync1_q;
    reg [3:0] sync2_q;
    reg link_clk_prev_q;
    reg [26:0] tmo_cnt_q;
    reg tmo_hit_q;
    reg prot_log_q;
    reg ovfl_log_q;
    reg eoc_log_q;
    reg tmo_sel_q;
    reg [15:0] scratch_q;
    reg prot_flood_q;
    reg ovfl_flood_q;
    reg prot_fatal_q;
    reg ack_q;
    reg [31:0] rdat_q;
    reg flood_q;
    reg fatal_q;
    reg [31:0] rdat_d;
    wire link_clk_s;
    wire ctl_s;
    wire prot_s;
    wire ovfl_s;
    wire link_rise;
    wire [26:0] tmo_limit;
    wire req;
    wire wr;
    wire [5:0] idx;
    wire [15:0] rate_mask;
    wire [15:0] feat;
    wire prot_set;
    wire ovfl_set;
    wire eoc_set;
    wire wr_le;
    wire wr_er;

    // Two-stage synchronisers for link clock, control lane and error lines
    always @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
            link_clk_prev_q <= 1'b0;
        end
        else
        begin
            sync1_q <= {OVFL_ERR, PROT_ERR, CONTROL_LANE, LINK_CLK};
            sync2_q <= sync1_q;
            link_clk_prev_q <= link_clk_s;
        end
    end

    assign link_clk_s = sync2_q[0];
    assign ctl_s = sync2_q[1];
    assign prot_s = sync2_q[2];
    assign ovfl_s = sync2_q[3];
    assign link_rise = link_clk_s & ~link_clk_prev_q;

    // Control lane low-time counter; limit chosen by the timeout bit
    assign tmo_limit = tmo_sel_q ? CTL_TMO_LONG_CYC : CTL_TMO_SHORT_CYC;

    always @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            tmo_cnt_q <= `LECR_RST_CNT;
            tmo_hit_q <= 1'b0;
        end
        else if (ctl_s)
        begin
            tmo_cnt_q <= `LECR_RST_CNT;
            tmo_hit_q <= 1'b0;
        end
        else if (tmo_cnt_q <= tmo_limit)
        begin
            // Counts one past the limit, so the hit fires once per low time
            tmo_cnt_q <= tmo_cnt_q + `LECR_CNT_ONE;
            tmo_hit_q <= (tmo_cnt_q == tmo_limit);
        end
        else
            tmo_hit_q <= 1'b0; // Parked past the limit until lane rises
    end

    // Error events; error lines are sampled on link clock rising edges
    assign prot_set = (HAS_PROT_CHECK != 0) &
                      ((link_rise & prot_s) | tmo_hit_q);
    assign ovfl_set = (HAS_OVFL_CHECK != 0) & link_rise & ovfl_s;
    assign eoc_set = (HAS_EOC_CHECK != 0) &
                     TX_POSTED_OR_RESP & END_OF_CHAIN;

    // Bus decode
    assign req = WB_CYC_I & WB_STB_I & ~ack_q;
    assign wr = req & WB_WE_I;
    assign idx = WB_ADR_I[`LECR_ADR_MSB:`LECR_ADR_LSB];
    assign wr_le = wr & WB_SEL_I[0] & (idx == `LECR_IDX_LINK_ERR);
    assign wr_er = wr & WB_SEL_I[0] & (idx == `LECR_IDX_ERR_ROUTE);

    // Log bits: hardware set wins over a write-one clear, sticky otherwise
    always @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            prot_log_q <= 1'b0;
            ovfl_log_q <= 1'b0;
            eoc_log_q <= 1'b0;
        end
        else
        begin
            prot_log_q <= prot_set | (prot_log_q &
                ~(wr_le & WB_DAT_I[`LECR_LE_PROT]));
            ovfl_log_q <= ovfl_set | (ovfl_log_q &
                ~(wr_le & WB_DAT_I[`LECR_LE_OVFL]));
            eoc_log_q <= eoc_set | (eoc_log_q &
                ~(wr_le & WB_DAT_I[`LECR_LE_EOC]));
        end
    end

    // Scratchpad, cleared only by cold reset
    always @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
            scratch_q <= `LECR_RST_HALF;
        else if (wr & (idx == `LECR_IDX_SCRATCH))
            scratch_q <= lecr_merge(scratch_q, WB_DAT_I[15:0],
                                    WB_SEL_I[1:0]);
    end

    // Warm-reset fields; no chain reset reaches the flood enables
    always @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            tmo_sel_q <= 1'b0;
            prot_flood_q <= 1'b0;
            ovfl_flood_q <= 1'b0;
            prot_fatal_q <= 1'b0;
        end
        else if (!WARM_RST_N)
        begin
            tmo_sel_q <= 1'b0;
            prot_flood_q <= 1'b0;
            ovfl_flood_q <= 1'b0;
            prot_fatal_q <= 1'b0;
        end
        else
        begin
            if (wr_le)
                tmo_sel_q <= (HAS_PROT_CHECK != 0) &
                             WB_DAT_I[`LECR_LE_TMO];
            if (wr_er)
            begin
                prot_flood_q <= (HAS_PROT_CHECK != 0) &
                    WB_DAT_I[`LECR_ER_PROT_FLOOD];
                ovfl_flood_q <= (HAS_OVFL_CHECK != 0) &
                    WB_DAT_I[`LECR_ER_OVFL_FLOOD];
                prot_fatal_q <= (HAS_PROT_CHECK != 0) &
                    (HAS_FATAL_IRQ != 0) &
                    WB_DAT_I[`LECR_ER_PROT_FATAL];
            end
        end
    end

    // Sync flood and fatal interrupt, registered
    always @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            flood_q <= 1'b0;
            fatal_q <= 1'b0;
        end
        else
        begin
            flood_q <= (prot_flood_q & prot_log_q) |
                       (ovfl_flood_q & ovfl_log_q);
            fatal_q <= prot_fatal_q & prot_log_q;
        end
    end

    assign SYNC_FLOOD = flood_q;
    assign FATAL_ERR = fatal_q;

    // Read-only capability words
    assign rate_mask = {(VENDOR_RATES != 0), RATE_SUPPORT[14:1],
                        1'b1};
    assign feat = {7'h00,
                   (HOST_OR_SECONDARY != 0),
                   4'h0,
                   (FEAT_EXT_CTL != 0),
                   (FEAT_CRC_TEST != 0),
                   (FEAT_STOP != 0),
                   (FEAT_ISOC != 0)};

    // Read mux; rate select nibble is not built here and reads zero
    always @*
    begin
        rdat_d = `LECR_RST_WORD;
        case (idx)
            `LECR_IDX_LINK_ERR:
                rdat_d[7:0] = {tmo_sel_q, eoc_log_q, ovfl_log_q,
                               prot_log_q, 4'h0};
            `LECR_IDX_RATE_SUP:
                rdat_d[15:0] = rate_mask;
            `LECR_IDX_FEATURES:
                rdat_d[15:0] = feat;
            `LECR_IDX_SCRATCH:
                rdat_d[15:0] = scratch_q;
            `LECR_IDX_ERR_ROUTE:
                rdat_d[2:0] = {prot_fatal_q, ovfl_flood_q, prot_flood_q};
            default:
                rdat_d = `LECR_RST_WORD;
        endcase
    end

    // Wishbone ack one cycle after request, dropped the next cycle
    always @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            ack_q <= 1'b0;
            rdat_q <= `LECR_RST_WORD;
        end
        else
        begin
            ack_q <= req;
            if (req)
                rdat_q <= WB_WE_I ? `LECR_RST_WORD : rdat_d;
        end
    end

    assign WB_ACK_O = ack_q;
    assign WB_DAT_O = rdat_q;

endmodule // lecr_regs

//--- lecr_regs_properties.sv
// Checker for the link error and capability register bank.
// Assumes classic Wishbone with a registered one-cycle ack.
`timescale 1ns/100ps
`include "lecr_defines.vh"
module lecr_regs_props (
    input wire CLK_SYS,
    input wire RST_N,
    input wire WARM_RST_N,
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire WB_WE_I,
    input wire [7:0] WB_ADR_I,
    input wire [31:0] WB_DAT_O,
    input wire WB_ACK_O,
    input wire SYNC_FLOOD,
    input wire FATAL_ERR
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    // Read answer and the register it addresses
    wire rd = WB_ACK_O && !WB_WE_I;
    wire [5:0] ix = WB_ADR_I[7:2];
    a_ack_one_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held longer than one cycle");
    a_ack_answers_req: assert property
        (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("request not answered next cycle");
    a_link_err_byte: assert property (
        rd && ix == `LECR_IDX_LINK_ERR |-> WB_DAT_O[3:0] == 4'h0
        && WB_DAT_O[31:8] == 24'h000000)
        else $error("link error byte holds stray bits");
    a_rate_mask_value: assert property (
        rd && ix == `LECR_IDX_RATE_SUP |-> WB_DAT_O == 32'h00000001)
        else $error("rate support mask wrong");
    a_feature_flag_value: assert property (
        rd && ix == `LECR_IDX_FEATURES |-> WB_DAT_O == 32'h00000002)
        else $error("feature flags wrong");
    a_scratch_width: assert property (
        rd && ix == `LECR_IDX_SCRATCH |-> WB_DAT_O[31:16] == 16'h0000)
        else $error("scratchpad wider than sixteen bits");
    a_route_unused_zero: assert property (
        rd && ix == `LECR_IDX_ERR_ROUTE |-> WB_DAT_O[31:3] == 29'h0)
        else $error("unused routing bits not zero");
    a_warm_stops_flood: assert property (
        !WARM_RST_N |-> ##2 !SYNC_FLOOD)
        else $error("flood survives warm reset");
    a_warm_stops_fatal: assert property (
        !WARM_RST_N |-> ##2 !FATAL_ERR)
        else $error("fatal survives warm reset");
    // Main scenarios reached
    cover property (rd && ix == `LECR_IDX_SCRATCH);
    cover property ($rose(SYNC_FLOOD));
    cover property ($rose(FATAL_ERR));
endmodule // lecr_regs_props

bind lecr_regs lecr_regs_props lecr_regs_props_i (.CLK_SYS, .RST_N,
    .WARM_RST_N, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_DAT_O,
    .WB_ACK_O, .SYNC_FLOOD, .FATAL_ERR);

//--- lecr_peer.sv
// Peer device on the link: link clock, control lane, error lines.
// Assumes the block samples these lines with its own clock.
`timescale 1ns/100ps
module lecr_peer (
    output logic link_clk,
    output logic ctl_lane,
    output logic prot_err,
    output logic ovfl_err
);
    // Idle link: clock stands still, lane high, no errors
    initial
    begin
        link_clk = 1'b0;
        ctl_lane = 1'b1;
        prot_err = 1'b0;
        ovfl_err = 1'b0;
    end
    // Three link clocks of 64 ns with the error lines held across them
    task automatic frame(input logic p, input logic o);
        prot_err = p;
        ovfl_err = o;
        repeat (6) #32 link_clk = ~link_clk;
        #32 prot_err = 1'b0;
        ovfl_err = 1'b0;
    endtask
    // Holds the control lane low for t ns
    task automatic lane_low(input int t);
        ctl_lane = 1'b0;
        #(t) ctl_lane = 1'b1;
    endtask
endmodule // lecr_peer

//--- lecr_regs_tb.sv
// Self-checking bench for the link error and capability registers.
// Assumes the peer model drives the link side; timeouts shortened.
`timescale 1ns/100ps
`include "lecr_defines.vh"
module lecr_regs_tb;
    logic clk_sys, rst_n, warm_rst_n, cyc, stb, we, eoc, txp;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, v;
    wire [31:0] dat_o;
    wire ack, link_clk, lane, perr, oerr, flood, fatal;
    int bad_count, checks;
    lecr_regs #(.CTL_TMO_SHORT_CYC(27'd20), .CTL_TMO_LONG_CYC(27'd60))
    lecr_regs_i (.CLK_SYS(clk_sys), .RST_N(rst_n), .WARM_RST_N(warm_rst_n),
        .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
        .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
        .LINK_CLK(link_clk), .CONTROL_LANE(lane), .PROT_ERR(perr),
        .OVFL_ERR(oerr), .END_OF_CHAIN(eoc), .TX_POSTED_OR_RESP(txp),
        .SYNC_FLOOD(flood), .FATAL_ERR(fatal));
    lecr_peer lecr_peer_i (.link_clk(link_clk), .ctl_lane(lane),
        .prot_err(perr), .ovfl_err(oerr));
    // System clock, 8 ns period
    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // Compares one value and counts it
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // One classic Wishbone cycle; data taken at the ack edge
    task automatic wb(input logic w, input logic [5:0] ix,
        input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        {cyc, stb, we} <= {2'b11, w};
        adr <= {ix, 2'b00};
        wdat <= {16'h0000, d};
        do @(posedge clk_sys); while (ack !== 1'b1 && ++n < 50);
        if (ack !== 1'b1)
            bad_count++;
        rdat = dat_o;
        {cyc, stb} <= 2'b00;
    endtask
    task automatic rd_chk(input logic [5:0] ix, input logic [15:0] exp);
        wb(1'b0, ix, 16'h0000);
        chk(rdat[15:0], exp);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Watchdog against a hung handshake
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        bad_count++;
        end_of_test;
    end
    // Main sequence
    initial
    begin
        void'($urandom(32'h1ee83e61));
        {cyc, stb, we, eoc, txp, rst_n, warm_rst_n} = 7'h01;
        adr = 8'h00;
        sel = 4'h3;
        wdat = 32'h0;
        bad_count = 0;
        checks = 0;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd_chk(`LECR_IDX_LINK_ERR, 16'h0000);
        rd_chk(`LECR_IDX_RATE_SUP, 16'h0001);
        rd_chk(`LECR_IDX_FEATURES, 16'h0002);
        rd_chk(`LECR_IDX_ERR_ROUTE, 16'h0000);
        rd_chk(6'h0f, 16'h0000);
        wb(1'b1, `LECR_IDX_RATE_SUP, 16'hffff);
        rd_chk(`LECR_IDX_RATE_SUP, 16'h0001);
        wb(1'b1, `LECR_IDX_ERR_ROUTE, 16'hffff);
        rd_chk(`LECR_IDX_ERR_ROUTE, 16'h0007);
        repeat (4)
        begin
            v = $urandom;
            wb(1'b1, `LECR_IDX_SCRATCH, v[15:0]);
            rd_chk(`LECR_IDX_SCRATCH, v[15:0]);
        end
        // Lane zero only: upper byte must be kept
        sel <= 4'h1;
        wb(1'b1, `LECR_IDX_SCRATCH, ~v[15:0]);
        sel <= 4'h3;
        v[7:0] = ~v[7:0];
        rd_chk(`LECR_IDX_SCRATCH, v[15:0]);
        // Protocol error routed to flood and fatal, then cleared
        wb(1'b1, `LECR_IDX_ERR_ROUTE, 16'h0005);
        lecr_peer_i.frame(1'b1, 1'b0);
        repeat (20) @(posedge clk_sys);
        rd_chk(`LECR_IDX_LINK_ERR, 16'h0010);
        chk({14'h0, flood, fatal}, 16'h0003);
        wb(1'b1, `LECR_IDX_LINK_ERR, 16'h0010);
        rd_chk(`LECR_IDX_LINK_ERR, 16'h0000);
        chk({14'h0, flood, fatal}, 16'h0000);
        // Overflow floods but is not routed to fatal
        wb(1'b1, `LECR_IDX_ERR_ROUTE, 16'h0006);
        lecr_peer_i.frame(1'b0, 1'b1);
        rd_chk(`LECR_IDX_LINK_ERR, 16'h0020);
        chk({14'h0, flood, fatal}, 16'h0002);
        wb(1'b1, `LECR_IDX_LINK_ERR, 16'h0020);
        // Send at chain end logs, away from it does not
        for (int i = 0; i < 2; i++)
        begin
            @(posedge clk_sys);
            {eoc, txp} <= {i[0], 1'b1};
            @(posedge clk_sys);
            txp <= 1'b0;
            rd_chk(`LECR_IDX_LINK_ERR, i ? 16'h0040 : 16'h0000);
        end
        // Long lane timeout: 50 cycles low is fine, 80 is an error
        wb(1'b1, `LECR_IDX_LINK_ERR, 16'h00c0);
        rd_chk(`LECR_IDX_LINK_ERR, 16'h0080);
        lecr_peer_i.lane_low(400);
        rd_chk(`LECR_IDX_LINK_ERR, 16'h0080);
        lecr_peer_i.lane_low(640);
        rd_chk(`LECR_IDX_LINK_ERR, 16'h0090);
        // Warm reset keeps logs and scratch, clears controls
        @(posedge clk_sys);
        warm_rst_n <= 1'b0;
        @(posedge clk_sys);
        warm_rst_n <= 1'b1;
        rd_chk(`LECR_IDX_LINK_ERR, 16'h0010);
        rd_chk(`LECR_IDX_ERR_ROUTE, 16'h0000);
        rd_chk(`LECR_IDX_SCRATCH, v[15:0]);
        // Short lane timeout: 30 cycles low is an error
        wb(1'b1, `LECR_IDX_LINK_ERR, 16'h0010);
        lecr_peer_i.lane_low(240);
        rd_chk(`LECR_IDX_LINK_ERR, 16'h0010);
        end_of_test;
    end
endmodule // lecr_regs_tb
